// ==== logic/tcb_timer.sv ====
/*
  24-bit timer/counter with avalon-mm register slave.
  assumes a prescaler outside supplies a one-cycle tick on presc_tick_i,
  and that the timer pin wire is resolved from pin_o and pin_oe_o outside.
*/
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_timer import tcb_pkg::*; #(
  parameter int TIMER_ID = 0,
  parameter int CW       = `TCB_CW
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        presc_tick_i,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_o,
  output logic             match_irq_o,
  output logic             ovf_irq_o
);

  localparam bit IS_T0 = (TIMER_ID == 0);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic          ack_ff;
  logic [31:0]   rdata_ff;
  logic          te_ff;
  logic          overflow_irq_enable_ff;
  logic          match_irq_enable_ff;
  logic [3:0]    mode_ff;
  logic          inv_ff;
  logic          trm_ff;
  logic          dir_ff;
  logic          do_ff;
  logic          pce_ff;
  logic          tof_ff;
  logic          tcf_ff;
  logic [CW-1:0] preload_ff;
  logic [CW-1:0] match_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] capt_ff;
  logic          first_ff;
  logic          div_ff;
  logic          pulse_ff;
  logic          tog_ff;
  logic          pin_prev_ff;
  logic          pin_ff;
  logic          pin_oe_ff;
  tcb_meas_t     meas_ff;

  logic          pin_lvl;
  logic          wr_go;
  logic          wr_csw;
  logic [31:0]   csw_rd;
  logic [31:0]   csw_w;
  logic [31:0]   rd_mux;
  logic          en_set;
  logic          is_count;
  logic          is_meas;
  logic          run_ok;
  logic          tick;
  logic          step;
  logic          act_edge;
  logic          opp_edge;
  logic [CW-1:0] nxt_cnt;
  logic          ovf_ev;
  logic          match_ev;
  logic          capt_ev;
  logic          reload_req;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------------
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
  assign wr_go             = avs_write_i & ack_ff;
  assign wr_csw            = wr_go & (avs_address_i == `TCB_ADR_CSW);
  assign csw_w             = be_merge(csw_rd, avs_writedata_i, avs_byteenable_i);
  assign en_set            = wr_csw & csw_w[`TCB_B_TE] & ~te_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
    end
  end

  always_comb begin
    csw_rd                            = `TCB_DATA_RST;
    csw_rd[`TCB_B_TE]                 = te_ff;
    csw_rd[`TCB_B_OVERFLOW_IRQ_ENABLE]               = overflow_irq_enable_ff;
    csw_rd[`TCB_B_MATCH_IRQ_ENABLE]               = match_irq_enable_ff;
    csw_rd[`TCB_B_TC_HI:`TCB_B_TC_LO] = mode_ff;
    csw_rd[`TCB_B_INV]                = inv_ff;
    csw_rd[`TCB_B_TRM]                = trm_ff;
    csw_rd[`TCB_B_DIR]                = dir_ff;
    csw_rd[`TCB_B_DI]                 = IS_T0 & (pin_lvl ^ inv_ff);
    csw_rd[`TCB_B_DO]                 = do_ff;
    csw_rd[`TCB_B_PCE]                = pce_ff;
    csw_rd[`TCB_B_TOF]                = tof_ff;
    csw_rd[`TCB_B_TCF]                = tcf_ff;
  end

  always_comb begin
    rd_mux = `TCB_DATA_RST;
    unique case (avs_address_i)
      `TCB_ADR_CSW:   rd_mux = csw_rd;
      `TCB_ADR_MATCH: rd_mux[CW-1:0] = match_ff;
      `TCB_ADR_COUNT: rd_mux[CW-1:0] = is_meas ? capt_ff : cnt_ff;
      default:        rd_mux = `TCB_DATA_RST; // preload is write-only
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= `TCB_DATA_RST;
    end else if (avs_read_i & ~ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  assign avs_readdata_o = rdata_ff;

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      te_ff   <= 1'b0;
      overflow_irq_enable_ff <= 1'b0;
      match_irq_enable_ff <= 1'b0;
      mode_ff <= `TCB_MODE_RST;
      inv_ff  <= 1'b0;
      trm_ff  <= 1'b0;
      dir_ff  <= 1'b0;
      do_ff   <= 1'b0;
      pce_ff  <= 1'b0;
    end else if (wr_csw) begin
      te_ff   <= csw_w[`TCB_B_TE];
      overflow_irq_enable_ff <= csw_w[`TCB_B_OVERFLOW_IRQ_ENABLE];
      match_irq_enable_ff <= csw_w[`TCB_B_MATCH_IRQ_ENABLE];
      mode_ff <= csw_w[`TCB_B_TC_HI:`TCB_B_TC_LO];
      inv_ff  <= csw_w[`TCB_B_INV];
      trm_ff  <= csw_w[`TCB_B_TRM];
      dir_ff  <= IS_T0 & csw_w[`TCB_B_DIR];
      do_ff   <= IS_T0 & csw_w[`TCB_B_DO];
      pce_ff  <= csw_w[`TCB_B_PCE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_ff <= `TCB_CNT_RST;
      match_ff   <= `TCB_CNT_RST;
    end else if (wr_go) begin
      if (avs_address_i == `TCB_ADR_PRELOAD) begin
        preload_ff <= CW'(be_merge(32'(preload_ff), avs_writedata_i,
                                   avs_byteenable_i));
      end
      if (avs_address_i == `TCB_ADR_MATCH) begin
        match_ff <= CW'(be_merge(32'(match_ff), avs_writedata_i, avs_byteenable_i));
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode decode and timer clock selection
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (mode_ff)
      `TCB_MODE_GPIO, `TCB_MODE_PULSE, `TCB_MODE_TOGGLE, `TCB_MODE_EVENT,
      `TCB_MODE_PWM, `TCB_MODE_WDPULSE, `TCB_MODE_WDTOG: begin
        is_count = 1'b1;
        is_meas  = 1'b0;
      end
      `TCB_MODE_WIDTH, `TCB_MODE_PERIOD, `TCB_MODE_CAPTURE: begin
        is_count = 1'b0;
        is_meas  = IS_T0;
      end
      default: begin
        is_count = 1'b0;
        is_meas  = 1'b0;
      end
    endcase
  end

  tcb_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (pin_i),
    .level_o (pin_lvl)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_lvl;
    end
  end

  // polarity chooses which edge is the active one
  assign act_edge = inv_ff ? (pin_prev_ff & ~pin_lvl) : (~pin_prev_ff & pin_lvl);
  assign opp_edge = inv_ff ? (~pin_prev_ff & pin_lvl) : (pin_prev_ff & ~pin_lvl);

  // system clock divided by two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= 1'b0;
    end else if (!te_ff) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
    end
  end

  always_comb begin
    if (pce_ff) begin
      tick = presc_tick_i;
    end else if (mode_ff == `TCB_MODE_EVENT) begin
      tick = IS_T0 ? act_edge : presc_tick_i;
    end else begin
      tick = div_ff;
    end
  end

  assign run_ok   = is_count | (is_meas & (meas_ff == TCB_M_RUN));
  assign step     = te_ff & tick & run_ok;
  assign nxt_cnt  = first_ff ? preload_ff : cnt_ff + CW'(1);
  assign ovf_ev   = step & ~first_ff & (cnt_ff == {CW{1'b1}});
  assign match_ev = step & is_count & (nxt_cnt == match_ff);

  // ----------------------------------------------------------------------
  // measurement sequencer (timer 0 only)
  // ----------------------------------------------------------------------
  always_comb begin
    capt_ev    = 1'b0;
    reload_req = 1'b0;
    if (te_ff & is_meas) begin
      unique case (mode_ff)
        `TCB_MODE_WIDTH: begin
          capt_ev    = (meas_ff == TCB_M_RUN) & opp_edge;
          reload_req = (meas_ff == TCB_M_WAIT) & act_edge & trm_ff;
        end
        `TCB_MODE_PERIOD: begin
          capt_ev    = (meas_ff == TCB_M_RUN) & act_edge;
          reload_req = capt_ev & trm_ff;
        end
        default: begin
          capt_ev = (meas_ff == TCB_M_RUN) & act_edge;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_ff <= TCB_M_WAIT;
    end else if (en_set) begin
      meas_ff <= (csw_w[`TCB_B_TC_HI:`TCB_B_TC_LO] == `TCB_MODE_CAPTURE) ? TCB_M_RUN
                                                                          : TCB_M_WAIT;
    end else if (te_ff & is_meas) begin
      unique case (meas_ff)
        TCB_M_WAIT: begin
          if (act_edge) begin
            meas_ff <= TCB_M_RUN;
          end
        end
        TCB_M_RUN: begin
          if (capt_ev & ((mode_ff == `TCB_MODE_CAPTURE) |
                         ((mode_ff == `TCB_MODE_WIDTH) & trm_ff))) begin
            meas_ff <= (mode_ff == `TCB_MODE_CAPTURE) ? TCB_M_HALT : TCB_M_WAIT;
          end
        end
        TCB_M_HALT: meas_ff <= TCB_M_HALT;
        default:    meas_ff <= TCB_M_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capt_ff <= `TCB_CNT_RST;
    end else if (capt_ev) begin
      capt_ff <= cnt_ff;
    end
  end

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= `TCB_CNT_RST;
    end else if (en_set) begin
      cnt_ff <= `TCB_CNT_RST;
    end else if (step) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // load pending: after enable, after a reloading match, on measurement reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_ff <= 1'b0;
    end else if (en_set) begin
      first_ff <= 1'b1;
    end else if ((match_ev & trm_ff) | reload_req) begin
      first_ff <= 1'b1;
    end else if (step) begin
      first_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // flags: set wins over write-one clear, disable clears
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tof_ff <= 1'b0;
      tcf_ff <= 1'b0;
    end else if (!te_ff) begin
      tof_ff <= 1'b0;
      tcf_ff <= 1'b0;
    end else begin
      if (ovf_ev) begin
        tof_ff <= 1'b1;
      end else if (wr_csw & avs_byteenable_i[2] & avs_writedata_i[`TCB_B_TOF]) begin
        tof_ff <= 1'b0;
      end
      if (match_ev | capt_ev) begin
        tcf_ff <= 1'b1;
      end else if (wr_csw & avs_byteenable_i[2] & avs_writedata_i[`TCB_B_TCF]) begin
        tcf_ff <= 1'b0;
      end
    end
  end

  assign match_irq_o = tcf_ff & match_irq_enable_ff;
  assign ovf_irq_o   = tof_ff & overflow_irq_enable_ff;

  // ----------------------------------------------------------------------
  // timer pin drive (timer 0 only)
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_ff <= 1'b0;
      tog_ff   <= 1'b0;
    end else if (en_set | ~te_ff) begin
      pulse_ff <= 1'b0;
      tog_ff   <= 1'b0;
    end else begin
      if (match_ev) begin
        pulse_ff <= 1'b1;
      end else if (step) begin
        pulse_ff <= 1'b0;
      end
      if (match_ev) begin
        tog_ff <= ~tog_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff    <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (!IS_T0) begin
      pin_ff    <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      unique case (mode_ff)
        `TCB_MODE_GPIO: begin
          pin_ff    <= do_ff ^ inv_ff;
          pin_oe_ff <= dir_ff;
        end
        `TCB_MODE_PULSE: begin
          pin_ff    <= inv_ff ^ pulse_ff;
          pin_oe_ff <= 1'b1;
        end
        `TCB_MODE_TOGGLE: begin
          pin_ff    <= inv_ff ^ tog_ff;
          pin_oe_ff <= 1'b1;
        end
        default: begin
          pin_ff    <= 1'b0;
          pin_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign pin_o    = pin_ff;
  assign pin_oe_o = pin_oe_ff;

endmodule : tcb_timer

// ==== inc/tcb_consts.svh ====
/*
  constants for the 24-bit timer/counter block: register byte offsets,
  control word bit positions, mode codes and reset values.
  assumes it is included by bare name from the timer logic files.
*/
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define TCB_ADR_CSW      5'h00
`define TCB_ADR_PRELOAD  5'h04
`define TCB_ADR_MATCH    5'h08
`define TCB_ADR_COUNT    5'h0c

// ----------------------------------------------------------------------
// control status word bit positions
// ----------------------------------------------------------------------
`define TCB_B_TE    0
`define TCB_B_OVERFLOW_IRQ_ENABLE  1
`define TCB_B_MATCH_IRQ_ENABLE  2
`define TCB_B_TC_LO 4
`define TCB_B_TC_HI 7
`define TCB_B_INV   8
`define TCB_B_TRM   9
`define TCB_B_DIR   11
`define TCB_B_DI    12
`define TCB_B_DO    13
`define TCB_B_PCE   15
`define TCB_B_TOF   20
`define TCB_B_TCF   21

// ----------------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------------
`define TCB_MODE_GPIO    4'h0
`define TCB_MODE_PULSE   4'h1
`define TCB_MODE_TOGGLE  4'h2
`define TCB_MODE_EVENT   4'h3
`define TCB_MODE_WIDTH   4'h4
`define TCB_MODE_PERIOD  4'h5
`define TCB_MODE_CAPTURE 4'h6
`define TCB_MODE_PWM     4'h7
`define TCB_MODE_WDPULSE 4'h9
`define TCB_MODE_WDTOG   4'ha

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define TCB_CW        24
`define TCB_CNT_RST   24'h000000
`define TCB_MODE_RST  4'h0
`define TCB_DATA_RST  32'h00000000

`endif

// ==== inc/tcb_pkg.sv ====
/*
  types shared by the timer/counter block.
  assumes nothing beyond a systemverilog compiler.
*/
package tcb_pkg;

  // measurement sequencer, gray coded along wait -> run -> halt
  typedef enum logic [1:0] {
    TCB_M_WAIT = 2'b00,
    TCB_M_RUN  = 2'b01,
    TCB_M_HALT = 2'b11
  } tcb_meas_t;

endpackage : tcb_pkg

// ==== logic/tcb_sync.sv ====
/*
  three-stage input synchroniser with agreement filter.
  assumes the input is asynchronous to clk_i; reset is synchronous.
*/
`timescale 1ns/1ps
module tcb_sync import tcb_pkg::*; (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic [2:0] stage_ff;
  logic       level_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_ff <= 3'h0;
    end else begin
      stage_ff <= {stage_ff[1:0], async_i};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ff <= 1'b0;
    end else if (stage_ff[1] == stage_ff[2]) begin
      level_ff <= stage_ff[2];
    end
  end

  assign level_o = level_ff;

endmodule : tcb_sync

// ==== sim/tcb_timer_assertions.sv ====
/*
  port checker for the 24-bit timer/counter: bus answer, readback, flags, pin.
  assumes it is bound onto tcb_timer and sees only its ports.
*/
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tcb_timer_assertions import tcb_pkg::*; #(
  parameter int TIMER_ID = 0,
  parameter int CW       = 24
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        presc_tick_i,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe_o,
  input wire logic        match_irq_o,
  input wire logic        ovf_irq_o
);
  // ----------------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic rd_done;
  logic csw_off;
  assign req     = avs_read_i | avs_write_i;
  assign rd_done = avs_read_i & ~avs_waitrequest_o;
  assign csw_off = avs_write_i & ~avs_waitrequest_o & (avs_address_i == `TCB_ADR_CSW)
                   & avs_byteenable_i[0] & ~avs_writedata_i[`TCB_B_TE];

  a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
    else $error("request start without a wait cycle");
  a_ack_one_wait: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait lasted more than one cycle");
  a_count_upper_zero: assert property (rd_done && avs_address_i == `TCB_ADR_COUNT |-> avs_readdata_o[31:24] == 8'h00)
    else $error("count readback wider than 24 bits");
  a_csw_reserved_zero: assert property (rd_done && avs_address_i == `TCB_ADR_CSW |-> (avs_readdata_o & 32'hffcf4408) == 32'h0)
    else $error("reserved control bits read nonzero");
  a_wo_unmapped_zero: assert property (rd_done && !(avs_address_i inside {`TCB_ADR_CSW, `TCB_ADR_MATCH, `TCB_ADR_COUNT}) |-> avs_readdata_o == 32'h0)
    else $error("write-only or unmapped read nonzero");
  a_off_clears_irq: assert property (csw_off |=> ##1 (!match_irq_o && !ovf_irq_o))
    else $error("interrupt level after disable");
  a_reset_clears_irq: assert property (disable iff (1'b0) rst_i |=> !match_irq_o && !ovf_irq_o)
    else $error("interrupt level after reset");
  a_readdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  a_pin_tick_rate: assert property (pin_oe_o && $past(pin_oe_o) && $changed(pin_o) |=> $stable(pin_o) || !pin_oe_o)
    else $error("pin changed faster than the timer clock");

  c_ovf: cover property ($rose(ovf_irq_o));
  c_match: cover property ($rose(match_irq_o));
  c_pin: cover property (pin_oe_o && $changed(pin_o));
endmodule : tcb_timer_assertions

bind tcb_timer tcb_timer_assertions #(.TIMER_ID(TIMER_ID), .CW(CW)) tcb_timer_assertions_i (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .presc_tick_i(presc_tick_i), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .match_irq_o(match_irq_o), .ovf_irq_o(ovf_irq_o));

// ==== sim/tcb_pin_src.sv ====
/*
  external signal source on the timer pin.
  assumes the testbench calls toggle() from its own sequence.
*/
`timescale 1ns/1ps
module tcb_pin_src import tcb_pkg::*; (
  input  wire logic clk_i,
  input  wire logic drv_i,
  input  wire logic oe_i,
  output logic      lvl_o
);
  // ----------------------------------------------------------------------
  // resolved pin level and source edges
  // ----------------------------------------------------------------------
  logic src_ff;
  initial src_ff = 1'b0;
  assign lvl_o = oe_i ? drv_i : src_ff;

  // edges spaced well below a quarter of the clock rate
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_i);
      src_ff <= ~src_ff;
    end
  endtask : toggle
endmodule : tcb_pin_src

// ==== sim/tb_top.sv ====
/*
  self-checking bench for the timer/counter, timer 0 with pin source model.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
`include "tcb_consts.svh"
module tb_top import tcb_pkg::*;;
  logic        clk_i, rst_i, rd, wr, presc;
  logic [4:0]  adr;
  logic [3:0]  be;
  logic [31:0] wd, rdat, v, r, c;
  logic        wreq, pin_o, pin_oe_o, match_irq_o, ovf_irq_o, pin_lvl;
  int          error_cnt, samples_checked, t;
  integer      seed;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  tcb_timer #(.TIMER_ID(0), .CW(24)) tcb_timer_i (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .presc_tick_i(presc), .pin_i(pin_lvl), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .match_irq_o(match_irq_o), .ovf_irq_o(ovf_irq_o));
  tcb_pin_src tcb_pin_src_i (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o), .lvl_o(pin_lvl));

  // ----------------------------------------------------------------------
  // bus, compare and model helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wd  <= d;
    wr  <= 1'b1;
    do @(posedge clk_i); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    rd  <= 1'b1;
    do @(posedge clk_i); while (wreq !== 1'b0);
    d = rdat;
    rd <= 1'b0;
  endtask : rd_reg

  function automatic logic [31:0] cw(input logic [3:0] m, input logic polarity_select, input logic auto_reload,
                                     input logic prescaled_source_select, input logic [1:0] ie);
    cw = 32'h0;
    cw[`TCB_B_TC_HI:`TCB_B_TC_LO] = m;
    cw[`TCB_B_INV] = polarity_select;
    cw[`TCB_B_TRM] = auto_reload;
    cw[`TCB_B_PCE] = prescaled_source_select;
    cw[`TCB_B_MATCH_IRQ_ENABLE:`TCB_B_OVERFLOW_IRQ_ENABLE] = ie;
  endfunction : cw

  task start(input logic [31:0] m);
    wr_reg(`TCB_ADR_CSW, m);
    wr_reg(`TCB_ADR_CSW, m | 32'h1);
  endtask : start

  task wait_chg(output int n);
    logic p;
    p = pin_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pin_o === p && n < 100);
  endtask : wait_chg

  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    error_cnt = 0; samples_checked = 0; seed = 32'he46626fc;
    rst_i = 1'b1; rd = 1'b0; wr = 1'b0; adr = 5'h00; wd = 32'h0; presc = 1'b0; be = 4'hf;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(`TCB_ADR_CSW, v); chk("csw reset", v, 32'h0);
    rd_reg(`TCB_ADR_COUNT, v); chk("count reset", v, 32'h0);
    r = $random(seed);
    wr_reg(`TCB_ADR_PRELOAD, r); rd_reg(`TCB_ADR_PRELOAD, v); chk("preload", v, 32'h0);
    wr_reg(`TCB_ADR_MATCH, r); rd_reg(`TCB_ADR_MATCH, v); chk("match", v, {8'h00, r[23:0]});
    wr_reg(5'h14, r); rd_reg(5'h14, v); chk("unmapped", v, 32'h0);
    // overflow with the match interrupt masked
    wr_reg(`TCB_ADR_PRELOAD, 32'h00fffffa); wr_reg(`TCB_ADR_MATCH, 32'h00fffffc);
    c = cw(`TCB_MODE_GPIO, 1'b0, 1'b0, 1'b0, 2'b01); start(c);
    t = 0;
    while (ovf_irq_o !== 1'b1 && t < 100) begin
      @(posedge clk_i);
      t++;
    end
    chk("ovf irq", ovf_irq_o, 32'h1);
    chk("match irq masked", match_irq_o, 32'h0);
    rd_reg(`TCB_ADR_CSW, v); chk("flags", v, c | 32'h00300001);
    rd_reg(`TCB_ADR_COUNT, v); chk("wrapped", v < 32'h10, 32'h1);
    rd_reg(`TCB_ADR_COUNT, r); chk("runs on", r > v, 32'h1);
    // flag clear ones without lane 2 enabled must not clear
    be <= 4'h3; wr_reg(`TCB_ADR_CSW, c | 32'h00300001); be <= 4'hf;
    rd_reg(`TCB_ADR_CSW, v); chk("lane 2 off", v, c | 32'h00300001);
    wr_reg(`TCB_ADR_CSW, c | 32'h00100001); rd_reg(`TCB_ADR_CSW, v);
    chk("w1c", v, c | 32'h00200001);
    wr_reg(`TCB_ADR_CSW, 32'h0); rd_reg(`TCB_ADR_CSW, v); chk("off", v, 32'h0);
    // pulse then toggle with auto reload
    wr_reg(`TCB_ADR_PRELOAD, 32'h100); wr_reg(`TCB_ADR_MATCH, 32'h102);
    for (int k = 0; k < 2; k++) begin
      c = cw(k ? `TCB_MODE_TOGGLE : `TCB_MODE_PULSE, k[0], 1'b1, 1'b0, 2'b10); start(c);
      repeat (3) @(posedge clk_i);
      chk("pin oe", pin_oe_o, 32'h1); chk("pin start", pin_o, k);
      wait_chg(t); wait_chg(t); chk("edge gap", t, k ? 6 : 2);
      wait_chg(t); chk("repeat gap", t, k ? 6 : 4);
      chk("match irq", match_irq_o, 32'h1);
      if (k == 0) begin
        wr_reg(`TCB_ADR_CSW, 32'h0);
      end else begin
        // mid-run reset while the match interrupt stands
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_reg(`TCB_ADR_CSW, v); chk("csw after reset", v, 32'h0);
        rd_reg(`TCB_ADR_MATCH, v); chk("match after reset", v, 32'h0);
        chk("outs after reset", {match_irq_o, ovf_irq_o, pin_oe_o}, 32'h0);
      end
    end
    // pin events in both polarities, from a low pin
    wr_reg(`TCB_ADR_PRELOAD, 32'ha);
    for (int k = 0; k < 2; k++) begin
      start(cw(`TCB_MODE_EVENT, k[0], 1'b0, 1'b0, 2'b00));
      rd_reg(`TCB_ADR_COUNT, v); chk("cleared", v, 32'h0);
      tcb_pin_src_i.toggle(5);
      repeat (10) @(posedge clk_i);
      rd_reg(`TCB_ADR_COUNT, v); chk("events", v, k ? 32'hb : 32'hc);
      wr_reg(`TCB_ADR_CSW, 32'h0);
      tcb_pin_src_i.toggle(1);
    end
    // prescaler ticks at random spacing
    start(cw(`TCB_MODE_EVENT, 1'b0, 1'b0, 1'b1, 2'b00));
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i) presc <= 1'b1;
      @(posedge clk_i) presc <= 1'b0;
      repeat ($random(seed) & 3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    rd_reg(`TCB_ADR_COUNT, v); chk("presc events", v, 32'h10);
    wr_reg(`TCB_ADR_CSW, 32'h0);
    // capture halts at the first rising edge
    start(cw(`TCB_MODE_CAPTURE, 1'b0, 1'b0, 1'b0, 2'b00));
    repeat (20) @(posedge clk_i);
    tcb_pin_src_i.toggle(1);
    repeat (10) @(posedge clk_i);
    rd_reg(`TCB_ADR_COUNT, v); repeat (6) @(posedge clk_i); rd_reg(`TCB_ADR_COUNT, r);
    chk("capture held", r, v);
    chk("capture range", v > 32'ha && v < 32'h20, 32'h1);
    rd_reg(`TCB_ADR_CSW, c); chk("capture flag", c[`TCB_B_TCF], 32'h1);
    // period between falling edges, pin now high: 8 ticks, first loads preload
    wr_reg(`TCB_ADR_CSW, 32'h0);
    start(cw(`TCB_MODE_PERIOD, 1'b1, 1'b0, 1'b0, 2'b00));
    tcb_pin_src_i.toggle(4);
    repeat (10) @(posedge clk_i);
    rd_reg(`TCB_ADR_COUNT, v);
    chk("period", v >= 32'h10 && v <= 32'h12, 32'h1);
    wrap_up();
  end
endmodule : tb_top
